// ==== tb/mmfs_core_model.sv ====
`timescale 1ns/10ps
`default_nettype none
// ==========
// core side: raises faults, follows sp
module mmfs_core_model
  import mmfs_pkg::*;
(
  input  wire logic        clk,   // clock
  input  wire logic        go,    // raise fault
  input  wire logic [1:0]  kind,  // fault kind
  input  wire logic        xn,    // execute-never
  input  wire logic [31:0] addr,  // access address
  input  wire mmfs_seq_t   seq,   // directives
  output mmfs_fault_t      fault, // fault event
  output logic [31:0]      sp     // stack pointer
);
  initial fault = '0;
  initial sp = 32'h00002000;
  // idle payload toggles so stale values never pass
  always @(posedge clk)
  begin
    fault <= go ? {1'b1, kind, xn, ~addr, addr} : {1'b0, ~fault[$bits(fault)-2:0]};
    if (seq.sp_load)
      sp <= seq.sp_value;
  end
endmodule // mmfs_core_model
`default_nettype wire

// ==== tb/mmfs_props.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "mmfs_params.svh"
// ==========
// fault flag checks
module mmfs_props
  import mmfs_pkg::*;
(
  input wire logic        CORE_CLK,        // clock
  input wire logic        RST,             // reset
  input wire mmfs_fault_t FAULT,           // fault in
  input wire logic [31:0] SP_IN,           // sp in
  input wire logic [3:0]  AVS_ADDRESS,     // address
  input wire logic        AVS_READ,        // read
  input wire logic        AVS_WRITE,       // write
  input wire logic [31:0] AVS_READDATA,    // read data
  input wire logic        AVS_WAITREQUEST, // stall
  input wire mmfs_seq_t   SEQ,             // directives
  input wire logic [31:0] SP_OUT,          // sp out
  input wire logic [3:0]  FLAGS            // flags
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (RST);
  wire logic ok = FAULT.valid && !FAULT.xn_region;
  wire logic stk = ok && FAULT.kind == MMFS_K_STACK;
  wire logic ust = ok && FAULT.kind == MMFS_K_UNSTACK;
  wire logic dat = ok && FAULT.kind == MMFS_K_DATA;
  wire logic ifx = FAULT.valid && (FAULT.xn_region || FAULT.kind == MMFS_K_FETCH);
  AST_STK: assert property (stk |=> FLAGS[3])
    else $error("stack flag");
  AST_STK_SP: assert property (stk |=> SP_OUT == $past(SP_IN) - `MMFS_FRAME_BYTES)
    else $error("stack sp");
  AST_UST: assert property (ust |=> FLAGS[2] && SEQ.chain && !SEQ.push
    && SP_OUT == $past(SP_OUT)) else $error("unstack");
  AST_DAT: assert property (dat |=> FLAGS[1] && SEQ.ret_pc == $past(FAULT.pc))
    else $error("data");
  AST_IFX: assert property (ifx |=> FLAGS[0] && SEQ.ret_pc == $past(FAULT.pc))
    else $error("fetch");
  AST_RST: assert property (disable iff (1'b0) RST |=> FLAGS == 4'h0)
    else $error("reset");
  AST_HOLD: assert property (!AVS_WRITE && !$past(AVS_WRITE) |=>
    (FLAGS & $past(FLAGS)) == $past(FLAGS)) else $error("flag lost");
  AST_RSVD: assert property (AVS_READ && AVS_ADDRESS == 4'h0 && !AVS_WAITREQUEST
    |-> !AVS_READDATA[2]) else $error("reserved bit");
  cover property (ust);
  cover property (FLAGS[1] && FLAGS[0]);
  cover property (AVS_WRITE && !AVS_WAITREQUEST);
endmodule // mmfs_props
bind mmfs_flags mmfs_props mmfs_props_i (.CORE_CLK(CORE_CLK), .RST(RST), .FAULT(FAULT),
  .SP_IN(SP_IN), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
  .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST), .SEQ(SEQ),
  .SP_OUT(SP_OUT), .FLAGS(FLAGS));
`default_nettype wire

// ==== tb/tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "mmfs_params.svh"
module tb_top
  import mmfs_pkg::*;
;
  logic        clk = 1'b0, rst = 1'b1, go = 1'b0, xn = 1'b0, rd_s = 1'b0, wr_s = 1'b0;
  logic [1:0]  kind = 2'h0;
  logic [3:0]  adr = 4'h0, be = 4'hF, flg;
  logic [31:0] fin = 32'h0, wd = 32'h0, rdat, rv, sp, spo, s0, fa = 32'h0;
  logic        wq, irq;
  mmfs_fault_t flt;
  mmfs_seq_t   seq;
  int          err_count = 0, tests_run = 0;
  // {kind, xn, flags, compare mask}
  logic [15:0] row [6] = '{16'h0088, 16'h1044, 16'h2022, 16'h3011, 16'h2111, 16'h0111};
  always #2.5 clk = ~clk;
  mmfs_core_model mmfs_core_model_i (.clk(clk), .go(go), .kind(kind), .xn(xn), .addr(fin),
    .seq(seq), .fault(flt), .sp(sp));
  mmfs_flags mmfs_flags_i (.CORE_CLK(clk), .RST(rst), .FAULT(flt), .SP_IN(sp),
    .AVS_ADDRESS(adr), .AVS_READ(rd_s), .AVS_WRITE(wr_s), .AVS_BYTEENABLE(be),
    .AVS_WRITEDATA(wd), .AVS_READDATA(rdat), .AVS_WAITREQUEST(wq), .SEQ(seq),
    .SP_OUT(spo), .FLAGS(flg), .IRQ(irq));
  // ==========
  // tasks
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e)
    begin
      err_count++;
      $display("[ERR] %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                     input logic [3:0] b);
    adr <= a;
    wd <= d;
    be <= b;
    wr_s <= w;
    rd_s <= !w;
    do @(posedge clk); while (wq !== 1'b0);
    rv = rdat;
    wr_s <= 1'b0;
    rd_s <= 1'b0;
    @(posedge clk);
  endtask
  task automatic fire(input logic [1:0] k, input logic x, input logic [31:0] a);
    kind <= k;
    xn <= x;
    fin <= a;
    go <= 1'b1;
    s0 = sp;
    @(posedge clk);
    go <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  task automatic tally_and_finish();
    if (err_count == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // ==========
  // sequence
  initial
  begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    bus(1'b0, 4'h0, 32'h0, 4'hF);
    chk("status", rv, 32'h0);
    foreach (row[i])
    begin
      bus(1'b1, 4'h0, 32'hFF, 4'hF);
      fire(row[i][13:12], row[i][8], 32'h100 * (i + 1));
      chk("flags", flg & row[i][3:0], row[i][7:4]);
      if (!row[i][8])
        chk("sp", spo, s0 - (row[i][13:12] == 2'h1 ? 32'h0 : `MMFS_FRAME_BYTES));
      if (row[i][15:8] == 8'h20)
        fa = 32'h100 * (i + 1);
      bus(1'b0, 4'h8, 32'h0, 4'hF);
      chk("addr", rv, fa);
    end
    fire(MMFS_K_DATA, 1'b0, 32'h40);
    chk("sticky", flg, 4'h3);
    bus(1'b1, 4'h0, 32'h0, 4'hF);
    bus(1'b1, 4'h0, 32'h1, 4'h0);
    chk("w0", flg, 4'h3);
    bus(1'b1, 4'h0, 32'h1, 4'hF);
    bus(1'b0, 4'h0, 32'h0, 4'hF);
    chk("w1c", rv[3:0], 4'h2);
    bus(1'b1, 4'h4, 32'h2, 4'hF);
    repeat (2) @(posedge clk);
    chk("irq", irq, 1'b1);
    bus(1'b1, 4'h4, 32'h1, 4'hF);
    repeat (2) @(posedge clk);
    chk("irq", irq, 1'b0);
    bus(1'b0, 4'h2, 32'h0, 4'hF);
    chk("unmapped", rv, 32'h0);
    tally_and_finish();
  end
  initial
  begin
    repeat (5000) @(posedge clk);
    err_count++;
    tally_and_finish();
  end
endmodule // tb_top
`default_nettype wire

// ==== verilog/mmfs_flags.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "mmfs_params.svh"
module mmfs_flags
  import mmfs_pkg::*;
(
  input  wire logic        CORE_CLK,         // core clock, 200 MHz
  input  wire logic        RST,              // sync reset, active high
  input  wire mmfs_fault_t FAULT,            // fault event from core
  input  wire logic [31:0] SP_IN,            // stack pointer before event
  input  wire logic [3:0]  AVS_ADDRESS,      // byte address
  input  wire logic        AVS_READ,         // read strobe
  input  wire logic        AVS_WRITE,        // write strobe
  input  wire logic [3:0]  AVS_BYTEENABLE,   // byte lanes
  input  wire logic [31:0] AVS_WRITEDATA,    // write data
  output logic [31:0]      AVS_READDATA,     // read data
  output logic             AVS_WAITREQUEST,  // stall
  output mmfs_seq_t        SEQ,              // directives to sequencer
  output logic [31:0]      SP_OUT,           // current stack pointer
  output logic [3:0]       FLAGS,            // stk,ustk,dviol,iviol
  output logic             IRQ               // level interrupt
);
  // ==========================================================
  // event decode
  // an execute-never hit is always an instruction violation, so it masks the kind code
  function automatic logic fault_is(input mmfs_fault_t f, input mmfs_kind_t k);
    fault_is = f.valid && !f.xn_region && f.kind == k;
  endfunction

  logic ev_stk, ev_ustk, ev_data, ev_fetch, cap_addr;
  always_comb
  begin
    ev_stk   = fault_is(FAULT, MMFS_K_STACK);   // RQ1
    ev_ustk  = fault_is(FAULT, MMFS_K_UNSTACK); // RQ4
    ev_data  = fault_is(FAULT, MMFS_K_DATA);    // RQ8
    // xn alone is enough; no protection-unit enable is consulted
    ev_fetch = FAULT.valid && (FAULT.kind == MMFS_K_FETCH || FAULT.xn_region); // RQ10 RQ11
    cap_addr = ev_data && !ev_fetch;                                 // RQ3 RQ6 RQ9 RQ12
  end

  // ==========================================================
  // bus slave: one wait cycle, answer on second edge
  logic        pend_q, pend_d;
  logic        wr_hit, rd_hit;
  logic [31:0] be_mask;
  always_comb
  begin
    pend_d  = (AVS_READ || AVS_WRITE) && !pend_q;
    wr_hit  = AVS_WRITE && pend_q;
    // read data is latched as waitrequest drops, so it stands when the master samples
    rd_hit  = AVS_READ && !pend_q;
    be_mask = {{8{AVS_BYTEENABLE[3]}}, {8{AVS_BYTEENABLE[2]}},
               {8{AVS_BYTEENABLE[1]}}, {8{AVS_BYTEENABLE[0]}}};
  end

  // ==========================================================
  // sticky status
  logic [7:0] set_v, clr_v, status, status_nx;
  always_comb
  begin
    set_v = 8'h00;
    set_v[`MMFS_BIT_STK]   = ev_stk;
    set_v[`MMFS_BIT_USTK]  = ev_ustk;
    set_v[`MMFS_BIT_DVIOL] = ev_data;
    set_v[`MMFS_BIT_IVIOL] = ev_fetch;
    set_v[`MMFS_BIT_ADDRV] = cap_addr;
    clr_v = 8'h00;
    if (wr_hit && AVS_ADDRESS == `MMFS_STATUS_OFS)
      clr_v = AVS_WRITEDATA[7:0] & be_mask[7:0] & `MMFS_STATUS_MASK; // RQ7 RQ13
    // same next state as the sticky cell, so flags and irq never lag it
    status_nx = (status & ~clr_v) | set_v; // RQ14
  end
  mmfs_w1c #(.W(8)) u_status (
    .clk (CORE_CLK),
    .rst (RST),
    .set (set_v),
    .clr (clr_v),
    .q   (status)
  );

  // ==========================================================
  // mask, address, stack pointer, sequencer directives
  logic [7:0]  mask_q, mask_d;
  logic [31:0] addr_q, addr_d, sp_q, sp_d, rdata_d;
  mmfs_seq_t   seq_d;
  logic        irq_d;
  always_comb
  begin
    mask_d = mask_q;
    if (wr_hit && AVS_ADDRESS == `MMFS_MASK_OFS && AVS_BYTEENABLE[0])
      mask_d = AVS_WRITEDATA[7:0] & `MMFS_STATUS_MASK;
    addr_d = cap_addr ? FAULT.addr : addr_q; // RQ3 RQ6 RQ9 RQ12
    sp_d   = SP_IN;
    seq_d  = '0;
    if (ev_stk)
    begin
      sp_d          = SP_IN - `MMFS_FRAME_BYTES; // RQ2
      seq_d.sp_load = 1'b1;                      // RQ2
      seq_d.push    = 1'b1;
    end
    else if (ev_ustk)
    begin
      sp_d        = sp_q;  // RQ6
      seq_d.chain = 1'b1;  // RQ5
    end
    else if (ev_data || ev_fetch)
    begin
      sp_d          = SP_IN - `MMFS_FRAME_BYTES;
      seq_d.sp_load = 1'b1;
      seq_d.push    = 1'b1;
      seq_d.ret_pc  = FAULT.pc; // RQ9 RQ12
    end
    seq_d.sp_value = sp_d;
    unique case (AVS_ADDRESS)
      `MMFS_STATUS_OFS: rdata_d = {24'h000000, status & `MMFS_STATUS_MASK}; // RQ7
      `MMFS_MASK_OFS:   rdata_d = {24'h000000, mask_q};
      `MMFS_ADDR_OFS:   rdata_d = addr_q;
      `MMFS_SP_OFS:     rdata_d = sp_q;
      default:          rdata_d = 32'h00000000;
    endcase
    if (!rd_hit)
      rdata_d = 32'h00000000;
    irq_d = |(status_nx & mask_d & `MMFS_STATUS_MASK);
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
    begin
      pend_q          <= 1'b0;
      mask_q          <= `MMFS_MASK_RST;
      addr_q          <= `MMFS_ADDR_RST;
      sp_q            <= `MMFS_SP_RST;
      SEQ             <= '0;
      SP_OUT          <= `MMFS_SP_RST;
      FLAGS           <= 4'h0;
      IRQ             <= 1'b0;
      AVS_READDATA    <= 32'h00000000;
      AVS_WAITREQUEST <= 1'b1;
    end
    else
    begin
      pend_q          <= pend_d;
      mask_q          <= mask_d;
      addr_q          <= addr_d;
      sp_q            <= sp_d;
      SEQ             <= seq_d;
      SP_OUT          <= sp_d;
      FLAGS           <= {status_nx[`MMFS_BIT_STK], status_nx[`MMFS_BIT_USTK],
                          status_nx[`MMFS_BIT_DVIOL], status_nx[`MMFS_BIT_IVIOL]};
      IRQ             <= irq_d;
      AVS_READDATA    <= rdata_d;
      AVS_WAITREQUEST <= !pend_d;
    end
  end
endmodule // mmfs_flags
`default_nettype wire

// ==== verilog/mmfs_params.svh ====
// Notes on behaviour
// (RQ1) A stacking fault during exception entry sets the stacking violation flag to one.
// (RQ2) On a stacking fault the stack pointer is still moved down as for a normal entry.
// (RQ3) On a stacking fault the fault address register keeps its old value.
// (RQ4) An unstacking fault on exception return sets the unstacking violation flag at bit 3.
// (RQ5) An unstacking fault chains to the handler, so the original return frame stays on the stack.
// (RQ6) On an unstacking fault the stack pointer stays put, nothing is pushed and no address is captured.
// (RQ7) Bit 2 is reserved, read only and reads as zero.
// (RQ8) A load or store that the region attributes forbid sets the data violation flag at bit 1.
// (RQ9) A data violation stacks the faulting instruction's address and captures the access address.
// (RQ10) A fetch from a non-executable location sets the instruction violation flag at bit 0.
// (RQ11) An instruction violation is raised on any execute-never region access, protection unit or not.
// (RQ12) An instruction violation stacks the faulting instruction's address and captures no address.
// (RQ13) Each flag resets to zero and is cleared only by writing one to it; writing zero does nothing.
// (RQ14) A flag stays set until cleared, and a new fault in the cycle of a clear wins.
`ifndef MMFS_PARAMS_SVH
`define MMFS_PARAMS_SVH
// ==========================================================
// register map (byte offsets)
`define MMFS_STATUS_OFS   4'h0
`define MMFS_MASK_OFS     4'h4
`define MMFS_ADDR_OFS     4'h8
`define MMFS_SP_OFS       4'hC
// ==========================================================
// status bit positions
`define MMFS_BIT_IVIOL    0
`define MMFS_BIT_DVIOL    1
`define MMFS_BIT_RSVD     2
`define MMFS_BIT_USTK     3
`define MMFS_BIT_STK      4
`define MMFS_BIT_ADDRV    7
`define MMFS_STATUS_MASK  8'h9B
`define MMFS_FLAGS_RST    8'h00
`define MMFS_MASK_RST     8'h00
`define MMFS_ADDR_RST     32'h00000000
`define MMFS_SP_RST       32'h00000000
`define MMFS_FRAME_BYTES  32'h00000020
`endif

// ==== verilog/mmfs_pkg.sv ====
package mmfs_pkg;
  typedef struct packed {
    logic        valid;     // one-cycle event
    logic [1:0]  kind;      // see mmfs_kind_t
    logic        xn_region; // target lies in an execute-never region
    logic [31:0] pc;        // faulting instruction address
    logic [31:0] addr;      // attempted access address
  } mmfs_fault_t;

  typedef enum logic [1:0] {
    MMFS_K_STACK   = 2'h0,
    MMFS_K_UNSTACK = 2'h1,
    MMFS_K_DATA    = 2'h2,
    MMFS_K_FETCH   = 2'h3
  } mmfs_kind_t;

  typedef struct packed {
    logic        sp_load;   // replace stack pointer
    logic [31:0] sp_value;
    logic        push;      // perform context save
    logic        chain;     // chain straight to handler
    logic [31:0] ret_pc;    // pc to be stacked
  } mmfs_seq_t;
endpackage

// ==== verilog/mmfs_w1c.sv ====
`timescale 1ns/10ps
`default_nettype none
module mmfs_w1c
  import mmfs_pkg::*;
#(
  parameter int W = 8
)(
  input  wire logic         clk,   // core clock
  input  wire logic         rst,   // sync reset
  input  wire logic [W-1:0] set,   // hardware events
  input  wire logic [W-1:0] clr,   // write-one-to-clear
  output logic      [W-1:0] q      // sticky bits
);
  logic [W-1:0] q_d;
  always_comb
  begin
    q_d = (q & ~clr) | set; // RQ13 RQ14
  end
  always_ff @(posedge clk)
  begin
    if (rst)
      q <= '0; // RQ13
    else
      q <= q_d;
  end
endmodule // mmfs_w1c
`default_nettype wire
